// >>> core/err_bank_pkg.sv
package err_bank_pkg;
   // Register addresses (7-bit register index on the config port)
   localparam logic [6:0] ADDR_ERROR_FLAGS = 7'h06;
   localparam logic [6:0] ADDR_ERROR_ENABLE = 7'h07;
   localparam logic [6:0] ADDR_CLOCK_COUNT = 7'h3d;
   // Reset values
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   localparam logic [15:0] ENABLE_RESET = 16'h0040;
   // Writable enable bits; 15..13 reserved
   localparam logic [15:0] ENABLE_WMASK = 16'h1fff;
   // Field positions
   localparam int BIT_ROM_CRC = 0;
   localparam int BIT_REGMAP_CRC = 1;
   localparam int BIT_SPI_CRC = 2;
   localparam int BIT_SPI_WRITE = 3;
   localparam int BIT_SPI_IGNORE = 6;
   localparam int BIT_NEG_RANGE = 10;
   localparam int BIT_POS_RANGE = 11;
   localparam int BIT_CLOCK_COUNTER = 12;
   // Cycles between map checksum passes
   localparam int MAP_CHECK_PERIOD = 256;
endpackage : err_bank_pkg

// >>> core/error_flag_and_enable_bank.sv
module error_flag_and_enable_bank #(
   parameter int CHECK_PERIOD = err_bank_pkg::MAP_CHECK_PERIOD
) (
   input wire logic sys_clk, // Master clock
   input wire logic rst_n, // Sync reset, low
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [6:0] reg_addr, // Register index
   input wire logic [15:0] reg_wdata, // Write data
   output logic [15:0] reg_rdata, // Read data
   output logic reg_hit, // Address belongs here
   input wire logic invalid_wr, // Write to invalid address
   input wire logic crc_mismatch, // Serial checksum error
   input wire logic access_ignored, // Transaction ignored
   input wire logic [15:0] map_checksum, // Live map checksum
   input wire logic map_written, // Any map write this cycle
   input wire logic rom_check_done, // ROM check finished, pulse
   input wire logic rom_check_bad, // ROM checksum mismatch
   input wire logic [15:4] ext_events, // Other flag sources
   output logic [15:0] error_flags, // Flag register
   output logic [15:0] error_enable_mask, // Enable register
   output logic [31:0] clock_count, // Master clock count
   output logic clock_counter_enable, // Bit 12 state
   output logic pos_input_range_enable, // Bit 11 state
   output logic neg_input_range_enable // Bit 10 state
);
   import err_bank_pkg::*;

   // Flag path
   logic [15:0] raw_events;
   logic [15:0] clear_mask;
   logic [15:0] next_flags;
   logic flags_wr;
   logic enable_wr;
   // Map checker state
   logic [15:0] ref_checksum;
   logic ref_valid;
   logic written_d;
   logic rebaseline;
   logic check_due;
   logic map_check_on;
   logic [$clog2(CHECK_PERIOD)-1:0] check_timer;
   logic [$clog2(CHECK_PERIOD)-1:0] timer_last;
   logic map_mismatch;
   // Read path
   logic [15:0] next_rdata;

   function automatic logic is_wr(input logic [6:0] a, input logic [6:0] t,
      input logic w);
      is_wr = w && (a == t);
   endfunction : is_wr

   // Write decode, one strobe each for the flag and enable registers
   assign flags_wr = is_wr(reg_addr, ADDR_ERROR_FLAGS, reg_wr);
   assign enable_wr = is_wr(reg_addr, ADDR_ERROR_ENABLE, reg_wr);

   // Enable register; reserved bits never stored
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         error_enable_mask <= ENABLE_RESET;
      end
      else if (enable_wr)
      begin
         error_enable_mask <= reg_wdata & ENABLE_WMASK;
      end
   end

   // Function enables straight from the mask
   assign clock_counter_enable = error_enable_mask[BIT_CLOCK_COUNTER];
   assign pos_input_range_enable = error_enable_mask[BIT_POS_RANGE];
   assign neg_input_range_enable = error_enable_mask[BIT_NEG_RANGE];

   // Checker switch and last timer step
   assign map_check_on = error_enable_mask[BIT_REGMAP_CRC];
   assign timer_last = ($clog2(CHECK_PERIOD))'(CHECK_PERIOD - 1);

   // A legal write shows in the checksum one edge late,
   // so the strobe is stretched by one cycle
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         written_d <= 1'b0;
      end
      else
      begin
         written_d <= map_written;
      end
   end

   // Re-baseline around writes instead of flagging them
   assign rebaseline = map_written || written_d || !ref_valid;
   assign check_due = (check_timer == '0) && !map_written
      && !written_d;

   // Baseline valid from the second enabled cycle on
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || !map_check_on)
      begin
         ref_valid <= 1'b0;
      end
      else
      begin
         ref_valid <= 1'b1;
      end
   end

   // Reference checksum, captured on legal changes and on the first enabled cycle
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || !map_check_on)
      begin
         ref_checksum <= 16'h0000;
      end
      else if (rebaseline)
      begin
         ref_checksum <= map_checksum;
      end
   end

   // Pass timer; restarts on every re-baseline
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || !map_check_on)
      begin
         check_timer <= '0;
      end
      else if (rebaseline)
      begin
         check_timer <= '0;
      end
      else if (check_timer == timer_last)
      begin
         check_timer <= '0;
      end
      else
      begin
         check_timer <= check_timer + 1'b1;
      end
   end

   // Change seen with no write behind it
   assign map_mismatch = ref_valid && check_due
      && (map_checksum != ref_checksum);

   // Event sources, one bit per flag
   always_comb
   begin
      raw_events = {ext_events, 4'h0};
      raw_events[BIT_SPI_WRITE] = invalid_wr;
      raw_events[BIT_SPI_CRC] = crc_mismatch;
      raw_events[BIT_REGMAP_CRC] = map_mismatch;
      raw_events[BIT_ROM_CRC] = rom_check_done && rom_check_bad;
      raw_events[BIT_SPI_IGNORE] = access_ignored;
      raw_events[BIT_CLOCK_COUNTER] = 1'b0; // Bit 12 is a function
   end

   // Set beats clear in the same cycle
   always_comb
   begin
      clear_mask = flags_wr ? reg_wdata : 16'h0000;
      next_flags = (error_flags & ~clear_mask)
         | (raw_events & error_enable_mask);
   end

   // Flag register, sticky until written one
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         error_flags <= FLAGS_RESET;
      else
         error_flags <= next_flags;
   end

   // Master clock counter, cleared when disabled
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || !error_enable_mask[BIT_CLOCK_COUNTER])
         clock_count <= 32'h0000_0000;
      else
         clock_count <= clock_count + 32'h0000_0001;
   end

   // Read word select; unmapped indexes read zero
   always_comb
   begin
      next_rdata = reg_rdata;
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_ERROR_FLAGS: next_rdata = error_flags;
            ADDR_ERROR_ENABLE: next_rdata = error_enable_mask;
            ADDR_CLOCK_COUNT: next_rdata = clock_count[15:0];
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   // Read data register; holds until the next read
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 16'h0000;
      end
      else
      begin
         reg_rdata <= next_rdata;
      end
   end

   assign reg_hit = (reg_addr == ADDR_ERROR_FLAGS)
      || (reg_addr == ADDR_ERROR_ENABLE) || (reg_addr == ADDR_CLOCK_COUNT);
endmodule : error_flag_and_enable_bank

// >>> sim/error_flag_and_enable_bank_props.sv
module error_flag_and_enable_bank_props (
   input wire logic sys_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic reg_wr, // Write
   input wire logic [6:0] reg_addr, // Index
   input wire logic [15:0] reg_wdata, // Data
   input wire logic invalid_wr, // Event
   input wire logic access_ignored, // Event
   input wire logic rom_check_done, // Done
   input wire logic rom_check_bad, // Bad
   input wire logic [15:0] error_flags, // Flags
   input wire logic [15:0] error_enable_mask, // Mask
   input wire logic [31:0] clock_count, // Count
   input wire logic clock_counter_enable // Bit 12
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Short aliases keep each property but rom_flag_a and cnt_run_a on one line
   wire logic [15:0] f = error_flags;
   wire logic [15:0] m = error_enable_mask;
   wire logic clr = reg_wr && reg_addr == 7'h06 && reg_wdata[3];
   rsv_zero_a: assert property (m[15:13] == 3'h0)
      else $error("reserved mask bits set");
   gate_a: assert property ((f & ~$past(f | m)) == 16'h0)
      else $error("disabled flag rose");
   wr_flag_a: assert property (invalid_wr && m[3] |=> f[3])
      else $error("write flag missed");
   ign_flag_a: assert property (access_ignored && m[6] |=> f[6])
      else $error("ignore flag missed");
   rom_flag_a: assert property (m[0] && rom_check_done
      && rom_check_bad |=> f[0])
      else $error("rom flag missed");
   sticky_a: assert property (f[3] && !clr |=> f[3])
      else $error("flag dropped");
   clear_a: assert property (clr && !invalid_wr |=> !f[3])
      else $error("flag not cleared");
   cnt_run_a: assert property (clock_counter_enable [*2] |=>
      clock_count == $past(clock_count) + 32'h1)
      else $error("counter stalled");
endmodule : error_flag_and_enable_bank_props
bind error_flag_and_enable_bank error_flag_and_enable_bank_props u_props (.*);

// >>> sim/error_flag_and_enable_bank_tb_top.sv
module error_flag_and_enable_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import err_bank_pkg::*;
   logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, upset = 0;
   logic [6:0] reg_addr = 7'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, map_checksum;
   // Map write, pos/neg range, write, crc, ignore, rom done, rom bad
   logic [7:0] ev = 8'h00;
   logic pre, nre;
   int mismatches = 0, compares = 0;
   // 250 MHz
   always #2 sys_clk = ~sys_clk;
   map_model u_map_model (.sys_clk(sys_clk), .rst_n(rst_n), .upset(upset),
      .map_checksum(map_checksum));
   error_flag_and_enable_bank #(.CHECK_PERIOD(4)) u_error_flag_and_enable_bank (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_hit(), .invalid_wr(ev[4]), .crc_mismatch(ev[3]),
      .access_ignored(ev[2]), .map_checksum(map_checksum),
      .map_written(ev[7]), .rom_check_done(ev[1]), .rom_check_bad(ev[0]),
      .ext_events({4'h0, ev[6:5], 6'h00}),
      .error_flags(), .error_enable_mask(), .clock_count(),
      .clock_counter_enable(), .pos_input_range_enable(pre),
      .neg_input_range_enable(nre));
   task automatic chk(input logic [15:0] s, e, input string n);
      compares++;
      if (s !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data settles one cycle after the strobe is taken
   task automatic rd(input logic [6:0] a, input logic [15:0] e, string n);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      chk(reg_rdata, e, n);
   endtask : rd
   // Events are single-cycle pulses; ROM bad rides with done
   // Map changes whenever none of bits 6..0 is pulsed, with or without a map write
   task automatic pulse(input logic [7:0] v);
      @(posedge sys_clk);
      {ev, upset} <= {v, v[6:0] == 7'h00};
      @(posedge sys_clk);
      {ev, upset} <= 9'h000;
   endtask : pulse
   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   // Main sequence; the map check needs a few periods of 4 cycles
   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(ADDR_ERROR_ENABLE, 16'h0040, "mask");
      rd(ADDR_ERROR_FLAGS, 16'h0000, "flags");
      chk({pre, nre}, 16'h0, "range");
      pulse(8'h7f);
      rd(ADDR_ERROR_FLAGS, 16'h0040, "gated");
      wr(ADDR_ERROR_ENABLE, 16'hffff);
      // Counter starts on the edge after the mask lands
      rd(ADDR_CLOCK_COUNT, 16'h0001, "count run");
      rd(ADDR_ERROR_ENABLE, 16'h1fff, "mask");
      chk({pre, nre}, 16'h3, "range");
      pulse(8'h7f);
      rd(ADDR_ERROR_FLAGS, 16'h0c4d, "events");
      pulse(8'h80);
      repeat (12) @(posedge sys_clk);
      rd(ADDR_ERROR_FLAGS, 16'h0c4d, "written");
      pulse(8'h00);
      repeat (12) @(posedge sys_clk);
      rd(ADDR_ERROR_FLAGS, 16'h0c4f, "map");
      wr(ADDR_ERROR_FLAGS, 16'h0005);
      rd(ADDR_ERROR_FLAGS, 16'h0c4a, "w1c");
      wr(ADDR_ERROR_ENABLE, 16'h0000);
      rd(ADDR_CLOCK_COUNT, 16'h0000, "count");
      complete_run();
   end
endmodule : error_flag_and_enable_bank_tb_top

// >>> sim/map_model.sv
module map_model (
   input wire logic sys_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic upset, // Flip map bits
   output logic [15:0] map_checksum // Checksum
);
   timeunit 1ns;
   timeprecision 1ps;
   // Upset changes the map with no write, as a soft error would
   always_ff @(posedge sys_clk)
      map_checksum <= !rst_n ? 16'h5a3c : map_checksum ^ {16{upset}};
endmodule : map_model
